// ===== bench/pmr_regs_monitor.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module pmr_regs_monitor (
    input wire logic               clock,
    input wire logic               rst,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic               pready,
    input wire pmr_pkg::pmr_word_t prdata,
    input wire logic               pslverr,
    input wire logic               ext_enabled,
    input wire logic               cfg_req,
    input wire logic               trn_error,
    input wire pmr_pkg::pmr_fec_t  fec_mode,
    input wire logic               fec_done,
    input wire logic               train_fail,
    input wire logic               adv_bch288,
    input wire logic               adv_bch320,
    input wire logic [2:0]         rate_sel,
    input wire logic               retrain_req,
    input wire logic               hold_failure
);
    import pmr_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // read and write completion qualifiers
    logic rd_done;
    logic wr_ctl;
    assign rd_done = psel && penable && pready && !pwrite;
    assign wr_ctl = psel && penable && pready && pwrite && paddr == `PMR_OFF_EXT_CONTROL;

    a_phy_type_code: assert property (rd_done && paddr == `PMR_OFF_COMMON_STATUS |-> prdata[3:0] == 4'h4)
        else $error("phy type field wrong");
    a_ext_status_bits: assert property (rd_done && paddr == `PMR_OFF_EXT_STATUS |->
        prdata[31:9] == 23'h0 && prdata[0] == $past(ext_enabled)) else $error("ext status bits wrong");
    a_local_cap_word: assert property (rd_done && paddr == `PMR_OFF_EXT_CAP |-> prdata == 32'h3f)
        else $error("local capability wrong");
    a_remote_cap_zero: assert property (rd_done && paddr == `PMR_OFF_EXT_REMOTE_CAP |-> prdata[31:6] == 26'h0)
        else $error("remote capability upper bits set");
    a_mask_advert: assert property (wr_ctl |=> adv_bch288 != $past(pwdata[3]))
        else $error("mask bit not reflected");
    a_rate_select: assert property (wr_ctl |=> rate_sel == $past(pwdata[6:4]))
        else $error("rate select not reflected");
    a_adv320_fixed: assert property (adv_bch320 == 1'b1)
        else $error("bch320 advert dropped");
    a_cfg_answer: assert property (cfg_req |=> fec_done != train_fail)
        else $error("config decision missing");
    a_fec_legal: assert property (fec_done |-> fec_mode inside {[3'h0:3'h3]})
        else $error("illegal fec mode");
    a_error_react: assert property (trn_error |=> retrain_req || hold_failure)
        else $error("training error ignored");
    a_ready_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module testbench;
    import pmr_pkg::*;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ext_enabled = 1;
    logic        cfg_req = 0, remote_288 = 0, remote_320 = 0, trn_error = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0;
    pmr_nib_t    op_status = 0, trn_state = 0, trn_substate = 0;
    logic        pready, pslverr, fec_done, train_fail, adv_bch288, adv_bch320;
    logic        crc_enable, arc_control, retrain_req, hold_failure;
    logic [2:0]  rate_sel;
    pmr_word_t   prdata;
    pmr_fec_t    fec_mode;
    int          failures = 0, samples_checked = 0;
    logic [31:0] q;
    logic        e;

    pmr_regs DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .op_status(op_status), .trn_state(trn_state), .trn_substate(trn_substate),
        .ext_enabled(ext_enabled), .cfg_req(cfg_req), .remote_288(remote_288), .remote_320(remote_320),
        .trn_error(trn_error), .fec_mode(fec_mode), .fec_done(fec_done), .train_fail(train_fail),
        .adv_bch288(adv_bch288), .adv_bch320(adv_bch320), .rate_sel(rate_sel), .crc_enable(crc_enable),
        .arc_control(arc_control), .retrain_req(retrain_req), .hold_failure(hold_failure));

    always #20 clock = ~clock;

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic close_out();
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // one apb transfer; held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string n);
        apb(0, a, 0);
        chk(n, q, exp);
    endtask

    task automatic t_reset();
        chk("crc_enable", crc_enable, 1);
        chk("adv288", adv_bch288, 1);
        rd(`PMR_OFF_COMMON_CONTROL, 32'h2, "common ctl");
        rd(`PMR_OFF_EXT_CONTROL, 32'h0, "ext ctl");
        rd(`PMR_OFF_LANE_CAP, 32'h2, "lane cap");
        rd(`PMR_OFF_EXT_STATUS, 32'h1, "ext status");
        ext_enabled <= 0;
        rd(`PMR_OFF_EXT_STATUS, 32'h0, "ext status off");
        ext_enabled <= 1;
    endtask

    // each status code, with the previous one kept beside it
    task automatic t_opstat();
        pmr_nib_t codes[6] = '{4'h1, 4'h2, 4'h7, 4'h8, 4'hb, 4'h0};
        pmr_nib_t prev = 0;
        foreach (codes[i]) begin
            op_status <= codes[i];
            repeat (3) @(posedge clock);
            rd(`PMR_OFF_COMMON_STATUS, {20'h0, prev, codes[i], 4'h4}, "op status");
            prev = codes[i];
        end
    endtask

    task automatic t_access();
        apb(1, `PMR_OFF_COMMON_CONTROL, 32'h1);
        rd(`PMR_OFF_COMMON_CONTROL, 32'h1, "common ctl");
        chk("arc", arc_control, 1);
        apb(1, `PMR_OFF_COMMON_CONTROL, 32'h3);
        rd(`PMR_OFF_COMMON_CONTROL, 32'h3, "arc with crc");
        apb(1, `PMR_OFF_COMMON_CONTROL, 32'h2);
        rd(`PMR_OFF_COMMON_CONTROL, 32'h2, "arc cleared");
        chk("crc_enable", crc_enable, 1);
        chk("arc", arc_control, 0);
        apb(1, `PMR_OFF_REMOTE_LANE_CAP, 32'h2);
        apb(1, `PMR_OFF_REMOTE_LANE_CAP, 32'h3);
        rd(`PMR_OFF_REMOTE_LANE_CAP, 32'h2, "remote lane");
        apb(1, `PMR_OFF_EXT_REMOTE_CAP, 32'hffffffff);
        rd(`PMR_OFF_EXT_REMOTE_CAP, 32'h3f, "remote cap");
        apb(1, `PMR_OFF_EXT_CAP, 32'h0);
        rd(`PMR_OFF_EXT_CAP, 32'h3f, "local cap");
        apb(1, `PMR_OFF_EXT_CONTROL, 32'hab000000);
        rd(`PMR_OFF_EXT_CONTROL, 32'hab000000, "preserve");
        rd(12'h040, 32'h0, "unmapped data");
        chk("unmapped err", e, 1);
    endtask

    // one config decision under a given override, mask and partner support
    task automatic cfg(input logic [2:0] ov, input logic mk, input logic r8, input logic r0,
                       input logic [2:0] rt, input logic fl, input logic [2:0] md);
        apb(1, `PMR_OFF_EXT_CONTROL, {25'h0, rt, mk, ov});
        @(posedge clock);
        remote_288 <= r8; remote_320 <= r0; cfg_req <= 1;
        @(posedge clock);
        cfg_req <= 0;
        @(posedge clock);
        chk("adv288", adv_bch288, !mk);
        chk("rate_sel", rate_sel, rt);
        chk("train_fail", train_fail, fl);
        chk("fec_done", fec_done, !fl);
        if (!fl) chk("fec_mode", fec_mode, md);
        apb(0, `PMR_OFF_EXT_STATUS, 0);
        if (fl) chk("train status", q[2:1], 2);
        else chk("ext status", q, {23'h0, rt, md, 3'h3});
    endtask

    task automatic t_error();
        trn_state <= 4'h4; trn_substate <= 4'h3;
        apb(1, `PMR_OFF_SPEC_CONTROL, 32'h1);
        repeat (2) @(posedge clock);
        chk("hold released", hold_failure, 0);
        trn_error <= 1;
        @(posedge clock);
        trn_error <= 0;
        trn_state <= 4'h6; trn_substate <= 4'h0;
        @(posedge clock);
        chk("retrain", retrain_req, 1);
        rd(`PMR_OFF_SPEC_STATUS, 32'h3406, "spec status");
        trn_substate <= 4'h5; trn_state <= 4'hc;
        rd(`PMR_OFF_SPEC_STATUS, 32'h345c, "sub-state");
        apb(1, `PMR_OFF_SPEC_CONTROL, 32'h0);
        trn_error <= 1;
        @(posedge clock);
        trn_error <= 0;
        @(posedge clock);
        chk("hold", hold_failure, 1);
        chk("no retrain", retrain_req, 0);
    endtask

    // watchdog against a hung handshake
    initial begin
        #800000;
        failures++;
        close_out();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        t_reset();
        t_opstat();
        t_access();
        cfg(0, 0, 1, 1, 0, 0, 0);
        cfg(0, 1, 1, 1, 1, 0, 1);
        cfg(0, 0, 0, 1, 2, 0, 1);
        cfg(0, 0, 0, 0, 0, 1, 0);
        cfg(1, 0, 0, 0, 1, 0, 0);
        cfg(2, 0, 0, 0, 0, 0, 1);
        cfg(3, 0, 0, 0, 0, 0, 2);
        cfg(4, 0, 0, 0, 2, 0, 3);
        cfg(5, 0, 1, 1, 0, 0, 0);
        t_error();
        close_out();
    end
endmodule

bind pmr_regs pmr_regs_monitor u_mon (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_enabled(ext_enabled), .cfg_req(cfg_req), .trn_error(trn_error), .fec_mode(fec_mode),
    .fec_done(fec_done), .train_fail(train_fail), .adv_bch288(adv_bch288), .adv_bch320(adv_bch320),
    .rate_sel(rate_sel), .retrain_req(retrain_req), .hold_failure(hold_failure));

// ===== pkg/pmr_defs.svh
`ifndef PMR_DEFS_SVH
`define PMR_DEFS_SVH

// register byte offsets
`define PMR_OFF_COMMON_STATUS   12'h000
`define PMR_OFF_COMMON_CONTROL  12'h004
`define PMR_OFF_LANE_CAP        12'h008
`define PMR_OFF_REMOTE_LANE_CAP 12'h00c
`define PMR_OFF_EXT_STATUS      12'h010
`define PMR_OFF_EXT_CONTROL     12'h014
`define PMR_OFF_EXT_CAP         12'h018
`define PMR_OFF_EXT_REMOTE_CAP  12'h01c
`define PMR_OFF_SPEC_STATUS     12'h020
`define PMR_OFF_SPEC_CONTROL    12'h024

// fixed field values
`define PMR_PHY_TYPE            4'h4
`define PMR_ARC_MAX             1'h1
`define PMR_REV_MAX             2'h2
`define PMR_CRC_EN_RST          1'h1
`define PMR_RATE_RST            3'h0
`define PMR_OVR_RST             3'h0
`define PMR_LOCAL_REV_SUPPORT   2'h2
`define PMR_LOCAL_CAP           6'h3f

// operational status codes
`define PMR_OP_DOWN             4'h0

// training status codes
`define PMR_TRN_NONE            2'h0
`define PMR_TRN_OK              2'h1
`define PMR_TRN_FAIL            2'h2

// ext control field positions
`define PMR_CTL_OVR_LSB         0
`define PMR_CTL_MASK_BIT        3
`define PMR_CTL_RATE_LSB        4
`define PMR_CTL_RSVD_LSB        7

// override encodings
`define PMR_OVR_NEGOTIATE       3'h0
`define PMR_OVR_BCH288          3'h1
`define PMR_OVR_BCH320          3'h2
`define PMR_OVR_CRC             3'h3
`define PMR_OVR_RS              3'h4

// capability bit positions
`define PMR_CAP_BCH288          0
`define PMR_CAP_BCH320          1

`endif

// ===== pkg/pmr_pkg.sv
package pmr_pkg;

    typedef logic [3:0]  pmr_nib_t;
    typedef logic [31:0] pmr_word_t;

    // active error-correction modes as reported in status
    typedef enum logic [2:0] {
        PMR_FEC_BCH288 = 3'h0,
        PMR_FEC_BCH320 = 3'h1,
        PMR_FEC_CRC    = 3'h2,
        PMR_FEC_RS     = 3'h3
    } pmr_fec_t;

    // register indices after word decode
    typedef enum logic [3:0] {
        PMR_R_COMMON_STATUS   = 4'h0,
        PMR_R_COMMON_CONTROL  = 4'h1,
        PMR_R_LANE_CAP        = 4'h2,
        PMR_R_REMOTE_LANE_CAP = 4'h3,
        PMR_R_EXT_STATUS      = 4'h4,
        PMR_R_EXT_CONTROL     = 4'h5,
        PMR_R_EXT_CAP         = 4'h6,
        PMR_R_EXT_REMOTE_CAP  = 4'h7,
        PMR_R_SPEC_STATUS     = 4'h8,
        PMR_R_SPEC_CONTROL    = 4'h9,
        PMR_R_NONE            = 4'hf
    } pmr_reg_t;

    // full register-bank state
    typedef struct packed {
        logic      pready;
        pmr_word_t prdata;
        logic      pslverr;
        logic      arc_ctl;
        logic      crc_en;
        logic [1:0] rem_rev;
        logic [2:0] fec_ovr;
        logic      mask288;
        logic [2:0] rate_ctl;
        logic [24:0] ctl_rsvd;
        logic [5:0] rem_cap;
        logic      auto_rt;
        pmr_nib_t  op_last;
        pmr_nib_t  op_prev;
        logic [1:0] trn_st;
        logic [2:0] rate_act;
        pmr_nib_t  prev_state;
        pmr_nib_t  prev_sub;
        logic      restart;
        logic      hold_fail;
    } pmr_state_t;

endpackage

// ===== rtl/pmr_fec_resolve.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module pmr_fec_resolve (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             cfg_req,
    input  wire logic [2:0]       fec_ovr,
    input  wire logic [5:0]       local_cap,
    input  wire logic             mask288,
    input  wire logic             remote_288,
    input  wire logic             remote_320,
    output pmr_pkg::pmr_fec_t     fec_mode,
    output logic                  done,
    output logic                  fail
);
    import pmr_pkg::*;

    typedef struct packed {
        pmr_fec_t mode;
        logic     done;
        logic     fail;
    } pmr_res_t;

    pmr_res_t r_ff;
    pmr_res_t nxt_r;
    logic     both288;
    logic     both320;

    // masked 288 is not advertised, so it can never be agreed
    assign both288 = local_cap[`PMR_CAP_BCH288] & ~mask288 & remote_288;
    assign both320 = local_cap[`PMR_CAP_BCH320] & remote_320;

    // one decision per config request
    always_comb begin
        nxt_r      = r_ff;
        nxt_r.done = 1'b0;
        nxt_r.fail = 1'b0;
        if (cfg_req) begin
            nxt_r.done = 1'b1;
            unique case (fec_ovr)
                `PMR_OVR_BCH288: nxt_r.mode = PMR_FEC_BCH288;
                `PMR_OVR_BCH320: nxt_r.mode = PMR_FEC_BCH320;
                `PMR_OVR_CRC:    nxt_r.mode = PMR_FEC_CRC;
                `PMR_OVR_RS:     nxt_r.mode = PMR_FEC_RS;
                default: begin
                    // reserved codes fall back to negotiation
                    if (both288) begin
                        nxt_r.mode = PMR_FEC_BCH288;
                    end else if (both320) begin
                        nxt_r.mode = PMR_FEC_BCH320;
                    end else begin
                        nxt_r.done = 1'b0;
                        nxt_r.fail = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r_ff <= '{mode: PMR_FEC_BCH288, done: 1'b0, fail: 1'b0};
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign fec_mode = r_ff.mode;
    assign done     = r_ff.done;
    assign fail     = r_ff.fail;
endmodule

// ===== rtl/pmr_regs.sv
`timescale 1ns/10ps
`include "pmr_defs.svh"
module pmr_regs (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic                  pready,
    output pmr_pkg::pmr_word_t    prdata,
    output logic                  pslverr,
    input  wire pmr_pkg::pmr_nib_t op_status,
    input  wire pmr_pkg::pmr_nib_t trn_state,
    input  wire pmr_pkg::pmr_nib_t trn_substate,
    input  wire logic             ext_enabled,
    input  wire logic             cfg_req,
    input  wire logic             remote_288,
    input  wire logic             remote_320,
    input  wire logic             trn_error,
    output pmr_pkg::pmr_fec_t     fec_mode,
    output logic                  fec_done,
    output logic                  train_fail,
    output logic                  adv_bch288,
    output logic                  adv_bch320,
    output logic [2:0]            rate_sel,
    output logic                  crc_enable,
    output logic                  arc_control,
    output logic                  retrain_req,
    output logic                  hold_failure
);
    import pmr_pkg::*;

    pmr_state_t s_ff;
    pmr_state_t nxt_s;
    logic       res_done;
    logic       res_fail;
    pmr_fec_t   res_mode;
    logic       wr_commit;
    logic       rd_launch;
    pmr_reg_t   acc_reg;

    // word-aligned decode shared by read and write paths
    function automatic pmr_reg_t reg_of(input logic [11:0] a);
        unique case (a)
            `PMR_OFF_COMMON_STATUS:   reg_of = PMR_R_COMMON_STATUS;
            `PMR_OFF_COMMON_CONTROL:  reg_of = PMR_R_COMMON_CONTROL;
            `PMR_OFF_LANE_CAP:        reg_of = PMR_R_LANE_CAP;
            `PMR_OFF_REMOTE_LANE_CAP: reg_of = PMR_R_REMOTE_LANE_CAP;
            `PMR_OFF_EXT_STATUS:      reg_of = PMR_R_EXT_STATUS;
            `PMR_OFF_EXT_CONTROL:     reg_of = PMR_R_EXT_CONTROL;
            `PMR_OFF_EXT_CAP:         reg_of = PMR_R_EXT_CAP;
            `PMR_OFF_EXT_REMOTE_CAP:  reg_of = PMR_R_EXT_REMOTE_CAP;
            `PMR_OFF_SPEC_STATUS:     reg_of = PMR_R_SPEC_STATUS;
            `PMR_OFF_SPEC_CONTROL:    reg_of = PMR_R_SPEC_CONTROL;
            default:                  reg_of = PMR_R_NONE;
        endcase
    endfunction

    // read word assembly; unlisted bits read zero
    function automatic pmr_word_t read_word(input pmr_reg_t r, input pmr_state_t s, input pmr_fec_t m,
                                            input pmr_nib_t st, input pmr_nib_t sub, input logic en);
        read_word = 32'h0000_0000;
        unique case (r)
            PMR_R_COMMON_STATUS: begin
                read_word[3:0]   = `PMR_PHY_TYPE;
                read_word[7:4]   = s.op_last;
                read_word[11:8]  = s.op_prev;
            end
            PMR_R_COMMON_CONTROL: begin
                read_word[0]     = s.arc_ctl;
                read_word[1]     = s.crc_en;
            end
            PMR_R_LANE_CAP: begin
                // asym, asym+reversal, arc 3-4, lp 3-4 fields all stay zero
                read_word[1:0]   = `PMR_LOCAL_REV_SUPPORT;
            end
            PMR_R_REMOTE_LANE_CAP: begin
                read_word[1:0]   = s.rem_rev;
            end
            PMR_R_EXT_STATUS: begin
                read_word[0]     = en;
                read_word[2:1]   = s.trn_st;
                read_word[5:3]   = m;
                read_word[8:6]   = s.rate_act;
            end
            PMR_R_EXT_CONTROL: begin
                read_word[2:0]   = s.fec_ovr;
                read_word[3]     = s.mask288;
                read_word[6:4]   = s.rate_ctl;
                read_word[31:7]  = s.ctl_rsvd;
            end
            PMR_R_EXT_CAP: begin
                read_word[5:0]   = `PMR_LOCAL_CAP;
            end
            PMR_R_EXT_REMOTE_CAP: begin
                read_word[5:0]   = s.rem_cap;
            end
            PMR_R_SPEC_STATUS: begin
                read_word[3:0]   = st;
                read_word[7:4]   = sub;
                read_word[11:8]  = s.prev_state;
                read_word[15:12] = s.prev_sub;
            end
            PMR_R_SPEC_CONTROL: begin
                read_word[0]     = s.auto_rt;
            end
            default: begin
                read_word = 32'h0000_0000;
            end
        endcase
    endfunction

    // negotiation of the phit correction mode
    pmr_fec_resolve u_resolve (
        .clock      (clock),
        .rst        (rst),
        .cfg_req    (cfg_req),
        .fec_ovr    (s_ff.fec_ovr),
        .local_cap  (`PMR_LOCAL_CAP),
        .mask288    (s_ff.mask288),
        .remote_288 (remote_288),
        .remote_320 (remote_320),
        .fec_mode   (res_mode),
        .done       (res_done),
        .fail       (res_fail)
    );

    // one wait state: pready rises the cycle after access starts
    assign acc_reg   = reg_of(paddr);
    assign rd_launch = psel & penable & ~s_ff.pready;
    assign wr_commit = psel & penable & s_ff.pready & pwrite;

    // next-state for the whole bank
    always_comb begin
        nxt_s         = s_ff;
        nxt_s.restart = 1'b0;

        // apb answer: data captured on the same edge that raises pready so prdata is a flop
        nxt_s.pready = rd_launch;
        if (rd_launch) begin
            nxt_s.pslverr = (acc_reg == PMR_R_NONE);
            nxt_s.prdata  = pwrite ? 32'h0000_0000
                                   : read_word(acc_reg, s_ff, res_mode, trn_state, trn_substate, ext_enabled);
        end else begin
            nxt_s.pslverr = 1'b0;
            nxt_s.prdata  = 32'h0000_0000;
        end

        // writes land on the edge that sees pready high
        if (wr_commit) begin
            unique case (acc_reg)
                PMR_R_COMMON_CONTROL: begin
                    // arc field is one bit wide, so only codes 0 and 1 can be held
                    // crc enable sits beside it and must never gate the arc update
                    nxt_s.arc_ctl = pwdata[0];
                    nxt_s.crc_en  = pwdata[1];
                end
                PMR_R_REMOTE_LANE_CAP: begin
                    if (pwdata[1:0] <= `PMR_REV_MAX) begin
                        nxt_s.rem_rev = pwdata[1:0];
                    end
                end
                PMR_R_EXT_CONTROL: begin
                    nxt_s.fec_ovr  = pwdata[`PMR_CTL_OVR_LSB +: 3];
                    nxt_s.mask288  = pwdata[`PMR_CTL_MASK_BIT];
                    nxt_s.rate_ctl = pwdata[`PMR_CTL_RATE_LSB +: 3];
                    nxt_s.ctl_rsvd = pwdata[31:`PMR_CTL_RSVD_LSB];
                end
                PMR_R_EXT_REMOTE_CAP: begin
                    nxt_s.rem_cap = pwdata[5:0];
                end
                PMR_R_SPEC_CONTROL: begin
                    nxt_s.auto_rt = pwdata[0];
                end
                default: begin
                    nxt_s.rem_cap = s_ff.rem_cap;   // read-only or unmapped: no effect
                end
            endcase
        end

        // track operational status history
        if (op_status != s_ff.op_last) begin
            nxt_s.op_prev = s_ff.op_last;
            nxt_s.op_last = op_status;
        end

        // training outcome, rate applied at config time
        if (res_done) begin
            nxt_s.trn_st   = `PMR_TRN_OK;
            nxt_s.rate_act = s_ff.rate_ctl;
        end

        // failures: config negotiation or engine-reported error
        if (res_fail || trn_error) begin
            nxt_s.trn_st = `PMR_TRN_FAIL;
            if (s_ff.auto_rt) begin
                nxt_s.prev_state = trn_state;
                nxt_s.prev_sub   = trn_substate;
                nxt_s.restart    = 1'b1;
                nxt_s.hold_fail  = 1'b0;
            end else begin
                nxt_s.hold_fail  = 1'b1;
            end
        end else if (s_ff.auto_rt) begin
            // turning auto retrain on releases a held failure
            nxt_s.hold_fail = 1'b0;
        end
    end

    // single state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_ff <= '{
                pready:     1'b0,
                prdata:     32'h0000_0000,
                pslverr:    1'b0,
                arc_ctl:    1'b0,
                crc_en:     `PMR_CRC_EN_RST,
                rem_rev:    2'h0,
                fec_ovr:    `PMR_OVR_RST,
                mask288:    1'b0,
                rate_ctl:   `PMR_RATE_RST,
                ctl_rsvd:   25'h000_0000,
                rem_cap:    6'h00,
                auto_rt:    1'b0,
                op_last:    `PMR_OP_DOWN,
                op_prev:    `PMR_OP_DOWN,
                trn_st:     `PMR_TRN_NONE,
                rate_act:   `PMR_RATE_RST,
                prev_state: 4'h0,
                prev_sub:   4'h0,
                restart:    1'b0,
                hold_fail:  1'b0
            };
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from flops, except adv_bch320 tied high and adv_bch288 inverted from mask288
    assign pready       = s_ff.pready;
    assign prdata       = s_ff.prdata;
    assign pslverr      = s_ff.pslverr;
    assign fec_mode     = res_mode;
    assign fec_done     = res_done;
    assign train_fail   = res_fail;
    assign adv_bch288   = ~s_ff.mask288;
    assign adv_bch320   = 1'b1;
    assign rate_sel     = s_ff.rate_ctl;
    assign crc_enable   = s_ff.crc_en;
    assign arc_control  = s_ff.arc_ctl;
    assign retrain_req  = s_ff.restart;
    assign hold_failure = s_ff.hold_fail;
endmodule
